//--- design/tmc_pkg.sv
// constants, field layouts and types shared by the timer/counter block
package tmc_pkg;

    // ------------------------------------------------------------
    // register offsets, data width, reset values
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    localparam logic [11:0] TMC_ADDR_COUNT_LOW   = 12'h59C;
    localparam logic [11:0] TMC_ADDR_PERIOD_HIGH = 12'h59D;
    localparam logic [11:0] TMC_ADDR_CTRL0       = 12'h59E;
    localparam logic [11:0] TMC_ADDR_CTRL1       = 12'h59F;

    localparam logic [7:0]  TMC_RST_BYTE         = 8'h00;
    localparam logic [7:0]  TMC_BYTE_MAX         = 8'hFF;
    localparam logic [15:0] TMC_WORD_MAX         = 16'hFFFF;

    // ------------------------------------------------------------
    // scaler widths and synchronised source positions
    // ------------------------------------------------------------
    localparam int unsigned TMC_PRE_W  = 15;
    localparam int unsigned TMC_POST_W = 4;

    localparam int unsigned TMC_NSRC      = 6;
    localparam int unsigned TMC_SRC_PIN   = 0;
    localparam int unsigned TMC_SRC_HFOSC = 1;
    localparam int unsigned TMC_SRC_LFOSC = 2;
    localparam int unsigned TMC_SRC_MF500 = 3;
    localparam int unsigned TMC_SRC_SOSC  = 4;
    localparam int unsigned TMC_SRC_CELL1 = 5;

    // ------------------------------------------------------------
    // clock source select codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TMC_CS_PIN     = 3'b000,
        TMC_CS_PIN_INV = 3'b001,
        TMC_CS_INSTR   = 3'b010,
        TMC_CS_HFOSC   = 3'b011,
        TMC_CS_LFOSC   = 3'b100,
        TMC_CS_MF500   = 3'b101,
        TMC_CS_SOSC    = 3'b110,
        TMC_CS_CELL1   = 3'b111
    } tmc_clk_src_t;

    // ------------------------------------------------------------
    // control register layouts, msb first
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  module_enable_bit;
        logic                  rsvd;
        logic                  output_level_bit;
        logic                  timer_width_select;
        logic [TMC_POST_W-1:0] postscale_select;
    } tmc_ctrl0_t;

    typedef struct packed {
        tmc_clk_src_t clock_source_select;
        logic         sync_bypass_bit;
        logic [3:0]   prescale_select;
    } tmc_ctrl1_t;

endpackage : tmc_pkg

//--- design/tmc_timer.sv
// timer/counter with 8-bit period and 16-bit free-running modes
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module tmc_timer
(
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rstn,

    // register port
    input  wire logic [tmc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tmc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [tmc_pkg::DATA_W-1:0] reg_rdata,

    // raw clock sources, asynchronous to ref_clk
    input  wire logic                      count_pin,
    input  wire logic                      hf_osc,
    input  wire logic                      lf_osc,
    input  wire logic                      mf500_osc,
    input  wire logic                      sec_osc,
    input  wire logic                      cell1_out,

    // system side, same clock domain
    input  wire logic                      sleep_mode,
    input  wire logic                      timer_irq_enable,
    input  wire logic                      irq_flag_clr,

    // results
    output logic                           timer_output,
    output logic                           timer_irq_flag,
    output logic                           irq_req,
    output logic                           wake_req
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    tmc_pkg::tmc_ctrl0_t                ctrl0_r;
    tmc_pkg::tmc_ctrl1_t                ctrl1_r;
    logic [7:0]                         count_low_byte_r;
    logic [7:0]                         high_live_r;
    logic [7:0]                         period_or_high_byte_r;
    logic [7:0]                         period_buf_r;
    logic [tmc_pkg::TMC_NSRC-1:0]       src_async;
    logic [tmc_pkg::TMC_NSRC-1:0]       src_meta_r;
    logic [tmc_pkg::TMC_NSRC-1:0]       src_sync_r;
    logic                               sel_lvl;
    logic                               instr_sel;
    logic                               sel_prev_r;
    logic                               src_edge;
    logic                               run;
    logic [15:0]                        pre_one;
    logic [tmc_pkg::TMC_PRE_W-1:0]      pre_mask;
    logic [tmc_pkg::TMC_PRE_W-1:0]      pre_cnt_r;
    logic                               pre_tick;
    logic [tmc_pkg::TMC_POST_W-1:0]     post_cnt_r;
    logic                               wr_low;
    logic                               wr_high;
    logic                               wr_ctrl0;
    logic                               wr_ctrl1;
    logic                               rd_low;
    logic                               clr_scalers;
    logic                               match8;
    logic                               roll16;
    logic                               count_evt;
    logic                               post_hit;
    logic [15:0]                        count_word;
    logic [15:0]                        count_word_nxt;
    logic [7:0]                         rdata_nxt;

    // ------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------
    // strobes are one cycle and never overlap, so plain decode suffices
    assign wr_low   = reg_wr && (reg_addr == tmc_pkg::TMC_ADDR_COUNT_LOW);
    assign wr_high  = reg_wr && (reg_addr == tmc_pkg::TMC_ADDR_PERIOD_HIGH);
    assign wr_ctrl0 = reg_wr && (reg_addr == tmc_pkg::TMC_ADDR_CTRL0);
    assign wr_ctrl1 = reg_wr && (reg_addr == tmc_pkg::TMC_ADDR_CTRL1);
    assign rd_low   = reg_rd && (reg_addr == tmc_pkg::TMC_ADDR_COUNT_LOW);

    // scalers restart on any low or control write
    assign clr_scalers = wr_low || wr_ctrl0 || wr_ctrl1;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // output bit is read-only and the reserved bit reads zero
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl0_r <= tmc_pkg::tmc_ctrl0_t'(tmc_pkg::TMC_RST_BYTE);
        end
        else if (wr_ctrl0)
        begin
            ctrl0_r                  <= tmc_pkg::tmc_ctrl0_t'(reg_wdata);
            ctrl0_r.rsvd             <= 1'b0;
            ctrl0_r.output_level_bit <= 1'b0;
        end
    end

    // source, bypass and prescale selection
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl1_r <= tmc_pkg::tmc_ctrl1_t'(tmc_pkg::TMC_RST_BYTE);
        end
        else if (wr_ctrl1)
        begin
            ctrl1_r <= tmc_pkg::tmc_ctrl1_t'(reg_wdata);
        end
    end

    // ------------------------------------------------------------
    // source synchronisers
    // ------------------------------------------------------------
    assign src_async[tmc_pkg::TMC_SRC_PIN]   = count_pin;
    assign src_async[tmc_pkg::TMC_SRC_HFOSC] = hf_osc;
    assign src_async[tmc_pkg::TMC_SRC_LFOSC] = lf_osc;
    assign src_async[tmc_pkg::TMC_SRC_MF500] = mf500_osc;
    assign src_async[tmc_pkg::TMC_SRC_SOSC]  = sec_osc;
    assign src_async[tmc_pkg::TMC_SRC_CELL1] = cell1_out;

    // two stages; the first stage is read only by the second
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            src_meta_r <= '0;
            src_sync_r <= '0;
        end
        else
        begin
            src_meta_r <= src_async;
            src_sync_r <= src_meta_r;
        end
    end

    // ------------------------------------------------------------
    // clock source select
    // ------------------------------------------------------------
    // instruction clock is ref_clk itself: one tick per cycle outside sleep
    always_comb
    begin
        sel_lvl   = 1'b0;
        instr_sel = 1'b0;
        case (ctrl1_r.clock_source_select)
            tmc_pkg::TMC_CS_PIN:     sel_lvl = src_sync_r[tmc_pkg::TMC_SRC_PIN];
            tmc_pkg::TMC_CS_PIN_INV: sel_lvl = ~src_sync_r[tmc_pkg::TMC_SRC_PIN];
            tmc_pkg::TMC_CS_INSTR:   instr_sel = 1'b1;
            tmc_pkg::TMC_CS_HFOSC:   sel_lvl = src_sync_r[tmc_pkg::TMC_SRC_HFOSC];
            tmc_pkg::TMC_CS_LFOSC:   sel_lvl = src_sync_r[tmc_pkg::TMC_SRC_LFOSC];
            tmc_pkg::TMC_CS_MF500:   sel_lvl = src_sync_r[tmc_pkg::TMC_SRC_MF500];
            tmc_pkg::TMC_CS_SOSC:    sel_lvl = src_sync_r[tmc_pkg::TMC_SRC_SOSC];
            tmc_pkg::TMC_CS_CELL1:   sel_lvl = src_sync_r[tmc_pkg::TMC_SRC_CELL1];
            default:                 sel_lvl = 1'b0;
        endcase
    end

    // previous level for the rising-edge detector
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_prev_r <= 1'b0;
        end
        else
        begin
            sel_prev_r <= sel_lvl;
        end
    end

    // limitation: sources faster than half of ref_clk alias here
    assign src_edge = instr_sel ? ~sleep_mode : (sel_lvl & ~sel_prev_r);

    // sleep stops the synchronised path, and stops the instruction clock even with bypass set
    assign run = ctrl0_r.module_enable_bit
               & (ctrl1_r.sync_bypass_bit | ~sleep_mode);

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // mask of 2^N - 1; at N = 15 the shifted bit falls off the top
    assign pre_one  = 16'h0001 << ctrl1_r.prescale_select;
    assign pre_mask = pre_one[tmc_pkg::TMC_PRE_W-1:0] - 15'h0001;
    assign pre_tick = run && src_edge && ((pre_cnt_r & pre_mask) == pre_mask);

    // free-running divider counter, hidden from software
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pre_cnt_r <= '0;
        end
        else if (clr_scalers)
        begin
            pre_cnt_r <= '0;
        end
        else if (run && src_edge)
        begin
            pre_cnt_r <= pre_cnt_r + 15'h0001;
        end
    end

    // ------------------------------------------------------------
    // counter core
    // ------------------------------------------------------------
    assign count_word     = {high_live_r, count_low_byte_r};
    assign count_word_nxt = count_word + 16'h0001;
    assign match8 = !ctrl0_r.timer_width_select && (count_low_byte_r == period_buf_r);
    assign roll16 = ctrl0_r.timer_width_select && (count_word == tmc_pkg::TMC_WORD_MAX);

    // a low write in the same cycle as a tick wins and swallows it
    assign count_evt = pre_tick && !wr_low && (match8 || roll16);

    // count bytes and period buffer
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_low_byte_r <= tmc_pkg::TMC_RST_BYTE;
            high_live_r      <= tmc_pkg::TMC_RST_BYTE;
            period_buf_r     <= tmc_pkg::TMC_RST_BYTE;
        end
        else if (wr_low)
        begin
            count_low_byte_r <= reg_wdata;
            if (ctrl0_r.timer_width_select)
            begin
                high_live_r <= period_or_high_byte_r;
            end
        end
        else if (pre_tick)
        begin
            if (!ctrl0_r.timer_width_select)
            begin
                if (match8)
                begin
                    count_low_byte_r <= tmc_pkg::TMC_RST_BYTE;
                    period_buf_r     <= period_or_high_byte_r;
                end
                else
                begin
                    count_low_byte_r <= count_low_byte_r + 8'h01;
                end
            end
            else
            begin
                count_low_byte_r <= count_word_nxt[7:0];
                high_live_r      <= count_word_nxt[15:8];
            end
        end
    end

    // period (8-bit) or high byte buffer (16-bit)
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            period_or_high_byte_r <= tmc_pkg::TMC_RST_BYTE;
        end
        else if (wr_high)
        begin
            period_or_high_byte_r <= reg_wdata;
        end
        else if (rd_low && ctrl0_r.timer_width_select)
        begin
            period_or_high_byte_r <= high_live_r;
        end
    end

    // ------------------------------------------------------------
    // postscaler and output
    // ------------------------------------------------------------
    assign post_hit = count_evt && (post_cnt_r == ctrl0_r.postscale_select);

    // divider of match or rollover events
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            post_cnt_r <= '0;
        end
        else if (clr_scalers)
        begin
            post_cnt_r <= '0;
        end
        else if (post_hit)
        begin
            post_cnt_r <= '0;
        end
        else if (count_evt)
        begin
            post_cnt_r <= post_cnt_r + 4'h1;
        end
    end

    // output keeps its level across scaler clears
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timer_output <= 1'b0;
        end
        else if (post_hit)
        begin
            timer_output <= ~timer_output;
        end
    end

    // ------------------------------------------------------------
    // interrupt flag and requests
    // ------------------------------------------------------------
    // a toggle in the clearing cycle still sets the flag
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timer_irq_flag <= 1'b0;
        end
        else if (post_hit)
        begin
            timer_irq_flag <= 1'b1;
        end
        else if (irq_flag_clr)
        begin
            timer_irq_flag <= 1'b0;
        end
    end

    assign irq_req  = timer_irq_flag & timer_irq_enable;
    assign wake_req = irq_req & sleep_mode;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // read data stand for one cycle only, zero otherwise
    always_comb
    begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            tmc_pkg::TMC_ADDR_COUNT_LOW:   rdata_nxt = count_low_byte_r;
            tmc_pkg::TMC_ADDR_PERIOD_HIGH: rdata_nxt = period_or_high_byte_r;
            tmc_pkg::TMC_ADDR_CTRL0:
            begin
                rdata_nxt    = ctrl0_r;
                rdata_nxt[5] = timer_output;
            end
            tmc_pkg::TMC_ADDR_CTRL1:       rdata_nxt = ctrl1_r;
            default:                       rdata_nxt = 8'h00;
        endcase
    end

    // registered answer, one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= rdata_nxt;
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // tmc_timer

`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the timer/counter block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                       ref_clk = 1'b0;
    logic                       rstn = 1'b0;
    logic [tmc_pkg::ADDR_W-1:0] reg_addr = 12'h000;
    logic [7:0]                 reg_wdata = 8'h00;
    logic                       reg_wr = 1'b0;
    logic                       reg_rd = 1'b0;
    logic                       sleep_mode = 1'b0;
    logic                       timer_irq_enable = 1'b0;
    logic                       irq_flag_clr = 1'b0;
    wire logic [7:0]            reg_rdata;
    wire logic                  count_pin, hf_osc, lf_osc, mf500_osc, sec_osc, cell1_out;
    wire logic                  timer_output, timer_irq_flag, irq_req, wake_req;
    int                         fails = 0;
    int                         samples_checked = 0;
    int                         n;
    logic [7:0]                 rv;
    logic [7:0]                 o;
    // period, postscale, prescale, expected cycles between toggles
    int tab [8][4] = '{'{3,0,0,4}, '{3,1,0,8}, '{3,2,0,12}, '{3,15,0,64},
                       '{0,0,1,2}, '{0,0,3,8}, '{0,3,2,16}, '{0,0,15,32768}};
    int sp [8] = '{7, 7, 1, 9, 11, 13, 15, 17};

    always #50 ref_clk = ~ref_clk;

    tmc_timer u_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_pin(count_pin),
        .hf_osc(hf_osc), .lf_osc(lf_osc), .mf500_osc(mf500_osc), .sec_osc(sec_osc),
        .cell1_out(cell1_out), .sleep_mode(sleep_mode), .timer_irq_enable(timer_irq_enable),
        .irq_flag_clr(irq_flag_clr), .timer_output(timer_output), .timer_irq_flag(timer_irq_flag),
        .irq_req(irq_req), .wake_req(wake_req));
    tmc_src_model u_src (.count_pin(count_pin), .hf_osc(hf_osc), .lf_osc(lf_osc),
        .mf500_osc(mf500_osc), .sec_osc(sec_osc), .cell1_out(cell1_out));

    // ----------------------------------------
    // bus, compare and wait helpers
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            fails++;
            $display("wrong value at %0t: got %0d cycles want %0d", $time, got, exp);
        end
    endtask
    // cycles until the output next changes, bounded
    task automatic wait_tog(output int c);
        logic l;
        #1;
        l = timer_output;
        c = 0;
        while (timer_output === l && c < 70000)
        begin
            @(posedge ref_clk);
            #1;
            c++;
        end
    endtask
    // first interval may be partial after a reconfiguration
    task automatic measure(input int exp);
        int c;
        wait_tog(c);
        wait_tog(c);
        chkn(c, exp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 4; i++)
        begin
            rd(tmc_pkg::TMC_ADDR_COUNT_LOW + 12'(i), rv);
            chk(rv, 8'h00);
        end
        wr(12'h5A0, 8'hFF);
        rd(12'h5A0, rv);
        chk(rv, 8'h00);
        wr(tmc_pkg::TMC_ADDR_CTRL0, 8'h5F);
        rd(tmc_pkg::TMC_ADDR_CTRL0, rv);
        chk(rv & 8'hDF, 8'h1F);
        wr(tmc_pkg::TMC_ADDR_CTRL1, 8'hB7);
        rd(tmc_pkg::TMC_ADDR_CTRL1, rv);
        chk(rv, 8'hB7);
    endtask
    task automatic t_wide();
        wr(tmc_pkg::TMC_ADDR_CTRL0, 8'h10);
        wr(tmc_pkg::TMC_ADDR_PERIOD_HIGH, 8'hFF);
        wr(tmc_pkg::TMC_ADDR_COUNT_LOW, 8'hFD);
        rd(tmc_pkg::TMC_ADDR_COUNT_LOW, rv);
        chk(rv, 8'hFD);
        rd(tmc_pkg::TMC_ADDR_PERIOD_HIGH, rv);
        chk(rv, 8'hFF);
        wr(tmc_pkg::TMC_ADDR_CTRL1, 8'h40);
        wr(tmc_pkg::TMC_ADDR_CTRL0, 8'h90);
        wait_tog(n);
        chkn(n, 3);
        wr(tmc_pkg::TMC_ADDR_CTRL0, 8'h10);
        rd(tmc_pkg::TMC_ADDR_COUNT_LOW, rv);
        rd(tmc_pkg::TMC_ADDR_PERIOD_HIGH, rv);
        chk(rv, 8'h00);
        // buffered high write must not reach the live count yet
        wr(tmc_pkg::TMC_ADDR_PERIOD_HIGH, 8'h12);
        rd(tmc_pkg::TMC_ADDR_COUNT_LOW, rv);
        rd(tmc_pkg::TMC_ADDR_PERIOD_HIGH, rv);
        chk(rv, 8'h00);
        wr(tmc_pkg::TMC_ADDR_PERIOD_HIGH, 8'h12);
        wr(tmc_pkg::TMC_ADDR_COUNT_LOW, 8'h34);
        rd(tmc_pkg::TMC_ADDR_COUNT_LOW, rv);
        chk(rv, 8'h34);
        rd(tmc_pkg::TMC_ADDR_PERIOD_HIGH, rv);
        chk(rv, 8'h12);
    endtask
    task automatic t_eight();
        for (int i = 0; i < 8; i++)
        begin
            wr(tmc_pkg::TMC_ADDR_PERIOD_HIGH, 8'(tab[i][0]));
            wr(tmc_pkg::TMC_ADDR_CTRL1, 8'h40 | 8'(tab[i][2]));
            wr(tmc_pkg::TMC_ADDR_CTRL0, 8'h80 | 8'(tab[i][1]));
            measure(tab[i][3]);
        end
    endtask
    task automatic t_src();
        for (int i = 0; i < 8; i++)
        begin
            wr(tmc_pkg::TMC_ADDR_CTRL1, 8'(i) << 5);
            measure(sp[i]);
        end
    endtask
    task automatic t_sleep();
        wr(tmc_pkg::TMC_ADDR_CTRL1, 8'h00);
        timer_irq_enable <= 1'b1;
        sleep_mode <= 1'b1;
        repeat (5) @(posedge ref_clk);
        o = 8'(timer_output);
        repeat (40) @(posedge ref_clk);
        chk(8'(timer_output), o);
        wr(tmc_pkg::TMC_ADDR_CTRL1, 8'h10);
        measure(7);
        chk(8'(wake_req), 8'h01);
        @(posedge ref_clk);
        irq_flag_clr <= 1'b1;
        @(posedge ref_clk);
        irq_flag_clr <= 1'b0;
        #1;
        chk(8'(timer_irq_flag), 8'h00);
        // instruction clock is absent in sleep even with bypass set
        wr(tmc_pkg::TMC_ADDR_CTRL1, 8'h50);
        repeat (5) @(posedge ref_clk);
        o = 8'(timer_output);
        repeat (30) @(posedge ref_clk);
        chk(8'(timer_output), o);
        sleep_mode <= 1'b0;
    endtask

    // ----------------------------------------
    // verdict, main sequence, watchdog
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_wide();
        t_eight();
        t_src();
        t_sleep();
        results();
    end
    // about a fifth over the expected run length
    initial
    begin
        #8000000;
        fails++;
        results();
    end
endmodule // tb_top

`default_nettype wire

//--- verif/tmc_src_model.sv
// free-running clock sources that feed the timer's raw source inputs
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// one oscillator
// ----------------------------------------
module tmc_src_osc
#(
    parameter int HALF_NS = 350
)
(
    // clock out
    output var logic osc
);
    // start offset keeps edges clear of ref_clk edges, so spacing stays exact
    initial
    begin
        osc = 1'b0;
        #23;
        forever #(HALF_NS) osc = ~osc;
    end
endmodule // tmc_src_osc

// ----------------------------------------
// all six sources, each at its own rate
// ----------------------------------------
module tmc_src_model
(
    // raw sources
    output wire logic count_pin,
    output wire logic hf_osc,
    output wire logic lf_osc,
    output wire logic mf500_osc,
    output wire logic sec_osc,
    output wire logic cell1_out
);
    // distinct periods let the bench tell the sources apart
    tmc_src_osc u_pin (.osc(count_pin));
    tmc_src_osc #(.HALF_NS(450)) u_hf (.osc(hf_osc));
    tmc_src_osc #(.HALF_NS(550)) u_lf (.osc(lf_osc));
    tmc_src_osc #(.HALF_NS(650)) u_mf (.osc(mf500_osc));
    tmc_src_osc #(.HALF_NS(750)) u_sec (.osc(sec_osc));
    tmc_src_osc #(.HALF_NS(850)) u_cell (.osc(cell1_out));
endmodule // tmc_src_model

`default_nettype wire

//--- verif/tmc_timer_chk.sv
// port-level assertions for the timer/counter block
`timescale 1ns/1ns
`default_nettype none

module tmc_timer_chk
(
    // clock and reset
    input wire logic                        ref_clk,
    input wire logic                        rstn,
    // register port
    input wire logic [tmc_pkg::ADDR_W-1:0]  reg_addr,
    input wire logic [tmc_pkg::DATA_W-1:0]  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [tmc_pkg::DATA_W-1:0]  reg_rdata,
    // system side and results
    input wire logic                        sleep_mode,
    input wire logic                        timer_irq_enable,
    input wire logic                        irq_flag_clr,
    input wire logic                        timer_output,
    input wire logic                        timer_irq_flag,
    input wire logic                        irq_req,
    input wire logic                        wake_req
);
    // ----------------------------------------
    // clocking and sequences
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_off;
        reg_wr && reg_addr == tmc_pkg::TMC_ADDR_CTRL0 && !reg_wdata[7];
    endsequence
    sequence s_rd0;
        reg_rd && reg_addr == tmc_pkg::TMC_ADDR_CTRL0;
    endsequence
    sequence s_rdx;
        reg_rd && reg_addr[11:2] != 10'h167;
    endsequence

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_irq;
        irq_req == (timer_irq_flag && timer_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("irq request mismatch");
    property p_wake;
        wake_req == (irq_req && sleep_mode);
    endproperty
    a_wake: assert property (p_wake) else $error("wake request mismatch");
    property p_flag;
        $changed(timer_output) |-> timer_irq_flag;
    endproperty
    a_flag: assert property (p_flag) else $error("toggle without flag");
    property p_stick;
        timer_irq_flag && !irq_flag_clr |=> timer_irq_flag;
    endproperty
    a_stick: assert property (p_stick) else $error("flag dropped alone");
    property p_clr;
        irq_flag_clr ##1 $stable(timer_output) |-> !timer_irq_flag;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    // output bit reads back the level held at the read edge
    property p_rd0;
        s_rd0 |=> reg_rdata[5] == $past(timer_output) && !reg_rdata[6];
    endproperty
    a_rd0: assert property (p_rd0) else $error("output bit read wrong");
    property p_rdx;
        s_rdx |=> reg_rdata == 8'h00;
    endproperty
    a_rdx: assert property (p_rdx) else $error("unmapped read not zero");
    property p_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    // an edge already in flight may still land just after disabling
    property p_off;
        s_off ##1 (!reg_wr)[*3] |-> $stable(timer_output);
    endproperty
    a_off: assert property (p_off) else $error("toggle while disabled");
endmodule // tmc_timer_chk

bind tmc_timer tmc_timer_chk u_chk
(
    .ref_clk          (ref_clk),
    .rstn             (rstn),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .sleep_mode       (sleep_mode),
    .timer_irq_enable (timer_irq_enable),
    .irq_flag_clr     (irq_flag_clr),
    .timer_output     (timer_output),
    .timer_irq_flag   (timer_irq_flag),
    .irq_req          (irq_req),
    .wake_req         (wake_req)
);

`default_nettype wire
